/* File: rtl/dioc_top.sv */
// Display invert and panel on/off command decoder with memory-to-panel pixel path
//
// How it works
// RULE1: Host writes each command alone: select low, read high, byte on write rising edge.
// RULE2: Code 21 turns inversion on; panel pixels complemented, memory untouched.
// RULE3: Inversion-on while already inverted changes nothing.
// RULE4: Inversion is off after hardware or software reset.
// RULE5: Code 28 blanks the panel image; memory contents stay intact.
// RULE6: Display-off while already off changes nothing.
// RULE7: Code 29 shows memory content on the panel; memory untouched.
// RULE8: Display-on while already on changes nothing.
// RULE9: Panel image is off after hardware or software reset.
// RULE10: These commands touch no readable status bit.
// RULE11: Commands act in every mode, including sleep.
// RULE12: Code 20 turns inversion off; memory untouched.
// RULE13: Inversion complements every component; display off blanks while reads continue.
`timescale 1ns/10ps
`default_nettype none

// One colour component on its way to the panel: blanked, complemented or passed through
module dioc_comp_xform
  import dioc_pkg::*;
#(
  parameter int WIDTH = DIOC_COMP_W,
  parameter logic [WIDTH-1:0] BLANK = '0
)
(
  input wire logic show_i,                                // Panel image on
  input wire logic invert_i,                              // Inversion on
  input wire logic [WIDTH-1:0] comp_i,                    // Component read from frame memory
  output logic [WIDTH-1:0] comp_o                         // Component toward the panel
);

  always_comb
  begin
    comp_o = comp_i;
    if (!show_i)
    begin
      // Blank wins over inversion, so an off panel never shows a complemented blank
      comp_o = BLANK;
    end
    else if (invert_i)
    begin
      comp_o = ~comp_i;
    end
  end

endmodule

module dioc_top
  import dioc_pkg::*;
#(
  parameter dioc_pix_t BLANK_PIX = DIOC_BLANK_PIX
)
(
  input wire logic clk_sys_i,                             // System clock, 100 MHz
  input wire logic srst_i,                                // Hardware reset, synchronous, active high
  input wire logic sw_reset_i,                            // Software reset pulse from command decode
  input wire logic chip_select_n_i,                       // Chip select, active low
  input wire logic data_command_select_i,                 // Low selects command, high data
  input wire logic read_strobe_n_i,                       // Read strobe, active low
  input wire logic write_strobe_n_i,                      // Write strobe, byte taken on rising edge
  input wire logic [DIOC_BUS_W-1:0] bus_data_i,           // Parallel bus data
  input wire logic mem_pix_valid_i,                       // Pixel from frame memory is valid
  input wire dioc_pix_t mem_pix_i,                        // Pixel read from frame memory
  output logic mem_pix_ready_o,                           // Memory read may proceed
  output logic panel_pix_valid_o,                         // Panel pixel valid
  output dioc_pix_t panel_pix_o,                          // Pixel driven to the panel
  output logic invert_on_o,                               // Inversion state
  output logic display_on_o,                              // Panel image state
  output logic cmd_taken_o,                               // One of the four codes decoded, pulse
  output logic cmd_other_o                                // Some other command written, pulse
);

  dioc_bus_t bus_now;
  logic wr_prev_r;
  logic cmd_strobe;
  logic [DIOC_CODE_W-1:0] code;
  logic hit_inv_on;
  logic hit_inv_off;
  logic hit_disp_on;
  logic hit_disp_off;
  logic hit_any;
  logic [DIOC_COMP_W-1:0] red_nxt;
  logic [DIOC_COMP_W-1:0] green_nxt;
  logic [DIOC_COMP_W-1:0] blue_nxt;
  logic invert_r;
  logic invert_nxt;
  logic display_r;
  logic display_nxt;
  logic any_rst;
  logic cmd_taken_r;
  logic cmd_other_r;
  logic pix_valid_r;
  dioc_pix_t pix_r;
  dioc_pix_t pix_nxt;

  assign bus_now = '{chip_select_n: chip_select_n_i,
                     data_command_select: data_command_select_i,
                     read_strobe_n: read_strobe_n_i,
                     write_strobe_n: write_strobe_n_i,
                     data: bus_data_i};

  assign any_rst = srst_i | sw_reset_i;

  // Previous strobe level; idle high so a reset never fakes an edge
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      wr_prev_r <= DIOC_STROBE_IDLE;
    end
    else
    begin
      wr_prev_r <= bus_now.write_strobe_n;
    end
  end

  // Command byte taken on the strobe's rising edge; upper bus bits ignored
  assign cmd_strobe = !bus_now.chip_select_n && !bus_now.data_command_select &&
                      bus_now.read_strobe_n && !wr_prev_r && bus_now.write_strobe_n; // [RULE1]
  assign code = bus_now.data[DIOC_CODE_LSB +: DIOC_CODE_W];

  // No mode or sleep qualifier: the codes act in every state
  assign hit_inv_on = cmd_strobe && (code == DIOC_CMD_INV_ON);     // [RULE2] [RULE11]
  assign hit_inv_off = cmd_strobe && (code == DIOC_CMD_INV_OFF);   // [RULE12] [RULE11]
  assign hit_disp_off = cmd_strobe && (code == DIOC_CMD_DISP_OFF); // [RULE5] [RULE11]
  assign hit_disp_on = cmd_strobe && (code == DIOC_CMD_DISP_ON);   // [RULE7] [RULE11]

  // Any of the four codes; everything else is only reported, never acted on
  assign hit_any = hit_inv_on | hit_inv_off | hit_disp_on | hit_disp_off;

  // Fixed-value set and clear updates, so a repeat of the same command leaves the flag as it is
  always_comb
  begin
    invert_nxt = invert_r;
    if (hit_inv_on)
    begin
      invert_nxt = 1'b1;                                  // [RULE2] [RULE3]
    end
    else if (hit_inv_off)
    begin
      invert_nxt = 1'b0;                                  // [RULE12]
    end
  end

  always_comb
  begin
    display_nxt = display_r;
    if (hit_disp_on)
    begin
      display_nxt = 1'b1;                                 // [RULE7] [RULE8]
    end
    else if (hit_disp_off)
    begin
      display_nxt = 1'b0;                                 // [RULE5] [RULE6]
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    // Either reset wins over a command decoded on the same edge
    if (any_rst)
    begin
      invert_r <= DIOC_INV_RST;                           // [RULE4]
    end
    else
    begin
      invert_r <= invert_nxt;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (any_rst)
    begin
      display_r <= DIOC_DISP_RST;                         // [RULE9]
    end
    else
    begin
      display_r <= display_nxt;
    end
  end

  // Decode report only; nothing here feeds a status readback
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      cmd_taken_r <= 1'b0;
    end
    else
    begin
      cmd_taken_r <= hit_any;                             // [RULE10]
    end
  end

  // Other codes belong to neighbouring decoders; they only pulse here
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      cmd_other_r <= 1'b0;
    end
    else
    begin
      cmd_other_r <= cmd_strobe & ~hit_any;
    end
  end

  // Memory reads never stall, blanked or not, so refresh timing does not depend on the mode
  assign mem_pix_ready_o = 1'b1;                          // [RULE13]

  // Only the panel copy is altered; the memory side is read-only here
  dioc_comp_xform
  #(
    .WIDTH(DIOC_COMP_W),
    .BLANK(BLANK_PIX.red)
  )
  u_red
  (
    .show_i(display_r),                                   // [RULE5] [RULE13]
    .invert_i(invert_r),                                  // [RULE2] [RULE13]
    .comp_i(mem_pix_i.red),
    .comp_o(red_nxt)
  );

  dioc_comp_xform
  #(
    .WIDTH(DIOC_COMP_W),
    .BLANK(BLANK_PIX.green)
  )
  u_green
  (
    .show_i(display_r),                                   // [RULE5] [RULE13]
    .invert_i(invert_r),                                  // [RULE2] [RULE13]
    .comp_i(mem_pix_i.green),
    .comp_o(green_nxt)
  );

  dioc_comp_xform
  #(
    .WIDTH(DIOC_COMP_W),
    .BLANK(BLANK_PIX.blue)
  )
  u_blue
  (
    .show_i(display_r),                                   // [RULE5] [RULE13]
    .invert_i(invert_r),                                  // [RULE2] [RULE13]
    .comp_i(mem_pix_i.blue),
    .comp_o(blue_nxt)
  );

  // Separate component nets keep each instance the only driver of what it writes
  assign pix_nxt = '{red: red_nxt,
                     green: green_nxt,
                     blue: blue_nxt};

  // One pixel out for every pixel in, one clock later
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      pix_valid_r <= 1'b0;
    end
    else
    begin
      pix_valid_r <= mem_pix_valid_i;
    end
  end

  // Data holds between valid pixels, so the panel side sees no spurious change
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      pix_r <= BLANK_PIX;
    end
    else if (mem_pix_valid_i)
    begin
      pix_r <= pix_nxt;
    end
  end

  assign panel_pix_valid_o = pix_valid_r;
  assign panel_pix_o = pix_r;
  assign invert_on_o = invert_r;
  assign display_on_o = display_r;
  assign cmd_taken_o = cmd_taken_r;
  assign cmd_other_o = cmd_other_r;

endmodule

`default_nettype wire

/* File: rtl/dioc_pkg.sv */
// Constants and carrier types for the display invert and on/off command decoder
package dioc_pkg;

  // Command codes, low byte of the bus
  localparam logic [7:0] DIOC_CMD_INV_OFF = 8'h20;
  localparam logic [7:0] DIOC_CMD_INV_ON = 8'h21;
  localparam logic [7:0] DIOC_CMD_DISP_OFF = 8'h28;
  localparam logic [7:0] DIOC_CMD_DISP_ON = 8'h29;

  // Bus layout
  localparam int DIOC_BUS_W = 18;
  localparam int DIOC_CODE_LSB = 0;
  localparam int DIOC_CODE_W = 8;

  // Pixel layout: one colour component per field
  localparam int DIOC_COMP_W = 6;

  // Reset values of the mode flags
  localparam logic DIOC_INV_RST = 1'b0;
  localparam logic DIOC_DISP_RST = 1'b0;

  // Idle level of the active-low write strobe
  localparam logic DIOC_STROBE_IDLE = 1'b1;

  typedef struct packed {
    logic [DIOC_COMP_W-1:0] red;
    logic [DIOC_COMP_W-1:0] green;
    logic [DIOC_COMP_W-1:0] blue;
  } dioc_pix_t;

  // Bus pins sampled on the system clock
  typedef struct packed {
    logic chip_select_n;
    logic data_command_select;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [DIOC_BUS_W-1:0] data;
  } dioc_bus_t;

  // Blank pixel shown while the panel image is off
  localparam dioc_pix_t DIOC_BLANK_PIX = '{red: 6'h00, green: 6'h00, blue: 6'h00};

endpackage

/* File: verif/dioc_top_props.sv */
// Port assertions for the display invert and on/off command decoder
`timescale 1ns/10ps
`default_nettype none
module dioc_props
  import dioc_pkg::*;
(
  input wire logic clk_sys_i,                   // Clock
  input wire logic srst_i,                      // Reset
  input wire logic sw_reset_i,                  // Software reset
  input wire logic chip_select_n_i,             // Select
  input wire logic data_command_select_i,       // Command or data
  input wire logic read_strobe_n_i,             // Read strobe
  input wire logic write_strobe_n_i,            // Write strobe
  input wire logic [DIOC_BUS_W-1:0] bus_data_i, // Bus
  input wire logic mem_pix_valid_i,             // Pixel valid
  input wire dioc_pix_t mem_pix_i,              // Pixel in
  input wire logic mem_pix_ready_o,             // Ready
  input wire logic panel_pix_valid_o,           // Panel valid
  input wire dioc_pix_t panel_pix_o,            // Panel pixel
  input wire logic invert_on_o,                 // Inversion
  input wire logic display_on_o                 // Display
);
  logic wr_q;
  logic busy_q;
  wire logic [7:0] code = bus_data_i[7:0];
  // Software reset wins over a command on the same edge
  wire logic take = !wr_q && write_strobe_n_i && !chip_select_n_i && !data_command_select_i && read_strobe_n_i
    && !sw_reset_i;
  always_ff @(posedge clk_sys_i) wr_q <= srst_i | write_strobe_n_i;
  always_ff @(posedge clk_sys_i) busy_q <= take | sw_reset_i;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);
  a_inv_set: assert property (take && code == DIOC_CMD_INV_ON |-> ##[1:2] invert_on_o)
    else $error("inversion not set");
  a_inv_clear: assert property (take && code == DIOC_CMD_INV_OFF |-> ##[1:2] !invert_on_o)
    else $error("inversion not cleared");
  a_disp_off: assert property (take && code == DIOC_CMD_DISP_OFF |-> ##[1:2] !display_on_o)
    else $error("display not off");
  a_disp_on: assert property (take && code == DIOC_CMD_DISP_ON |-> ##[1:2] display_on_o)
    else $error("display not on");
  a_flags_hold: assert property (!$stable({invert_on_o, display_on_o}) |->
    busy_q || $past(busy_q) || $past(srst_i))
    else $error("flags changed without cause");
  a_hw_reset_off: assert property ($fell(srst_i) |-> !invert_on_o && !display_on_o)
    else $error("flags set after reset");
  a_sw_reset_off: assert property (sw_reset_i |=> !invert_on_o && !display_on_o)
    else $error("flags set after software reset");
  a_pix_shown: assert property (mem_pix_valid_i && display_on_o |=> panel_pix_valid_o
    && panel_pix_o == ($past(invert_on_o) ? ~$past(mem_pix_i) : $past(mem_pix_i)))
    else $error("panel pixel wrong");
  a_pix_blank: assert property (mem_pix_valid_i && !display_on_o |=> panel_pix_o == DIOC_BLANK_PIX)
    else $error("panel pixel not blank");
  a_ready_high: assert property (mem_pix_ready_o)
    else $error("memory read stalled");
endmodule

bind dioc_top dioc_props u_props (.clk_sys_i, .srst_i, .sw_reset_i, .chip_select_n_i, .data_command_select_i,
  .read_strobe_n_i, .write_strobe_n_i, .bus_data_i, .mem_pix_valid_i, .mem_pix_i, .mem_pix_ready_o,
  .panel_pix_valid_o, .panel_pix_o, .invert_on_o, .display_on_o);
`default_nettype wire

/* File: verif/dioc_host.sv */
// Host model writing single command bytes over the parallel bus
`timescale 1ns/10ps
`default_nettype none
module dioc_host
  import dioc_pkg::*;
(
  input wire logic clk_sys_i, // Clock
  output var dioc_bus_t bus_o // Bus toward the decoder
);
  initial bus_o = '{1'b1, 1'b0, 1'b1, DIOC_STROBE_IDLE, 18'h00000};
  task automatic write(input dioc_bus_t req);
    dioc_bus_t drv;
    drv = req;
    drv.write_strobe_n = 1'b0;
    @(negedge clk_sys_i);
    bus_o = drv;
    drv.write_strobe_n = 1'b1;
    @(negedge clk_sys_i);
    bus_o = drv; // Byte taken on this rising strobe
    // A released bus must not keep showing the old byte
    drv.data = ~drv.data;
    drv.chip_select_n = 1'b1;
    @(negedge clk_sys_i);
    bus_o = drv;
  endtask
endmodule
`default_nettype wire

/* File: verif/test_dioc_top.sv */
// Self-checking bench for the display invert and on/off command decoder
`timescale 1ns/10ps
`default_nettype none
module test_dioc_top;
  import dioc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic sw_reset_i = 1'b0;
  logic pix_valid = 1'b0;
  dioc_pix_t pix = 18'h00000;
  dioc_pix_t panel_pix;
  dioc_bus_t bus;
  logic panel_valid;
  logic inv_on;
  logic disp_on;
  logic taken;
  logic other;
  int seed = 32'hC4B0C006;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int r;
  logic [1:0] exp_f = 2'h0;
  logic [7:0] tbl [4] = '{DIOC_CMD_INV_OFF, DIOC_CMD_INV_ON, DIOC_CMD_DISP_OFF, DIOC_CMD_DISP_ON};
  always #5 clk_sys_i = ~clk_sys_i;
  dioc_host u_host (.clk_sys_i, .bus_o(bus));
  dioc_top u_dut (.clk_sys_i, .srst_i, .sw_reset_i, .chip_select_n_i(bus.chip_select_n),
    .data_command_select_i(bus.data_command_select), .read_strobe_n_i(bus.read_strobe_n),
    .write_strobe_n_i(bus.write_strobe_n), .bus_data_i(bus.data), .mem_pix_valid_i(pix_valid), .mem_pix_i(pix),
    .mem_pix_ready_o(), .panel_pix_valid_o(panel_valid), .panel_pix_o(panel_pix), .invert_on_o(inv_on),
    .display_on_o(disp_on), .cmd_taken_o(taken), .cmd_other_o(other));
  task chk(input logic [19:0] seen, input logic [19:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task give_verdict;
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function logic [17:0] shown(input logic [1:0] f, input dioc_pix_t p);
    return !f[0] ? 18'h00000 : (f[1] ? ~p : p);
  endfunction
  task pixels(input int n);
    dioc_pix_t p;
    repeat (n)
    begin
      pix_valid = 1'b1;
      pix = dioc_pix_t'(18'($random(seed)));
      p = pix;
      @(negedge clk_sys_i);
      chk({panel_valid, panel_pix}, {1'b1, shown(exp_f, p)});
    end
    pix_valid = 1'b0;
  endtask
  task cmd(input logic [7:0] c, input logic ok);
    dioc_bus_t q;
    logic known;
    q = dioc_bus_t'(22'($random(seed)));
    q.data[7:0] = c;
    if (ok)
      q[21:19] = 3'h1;
    u_host.write(q);
    known = (c == DIOC_CMD_INV_OFF) || (c == DIOC_CMD_INV_ON) || (c == DIOC_CMD_DISP_OFF) ||
      (c == DIOC_CMD_DISP_ON);
    // Decode pulses stand for the one cycle right after the taking edge
    chk({taken, other}, (q[21:19] == 3'h1) ? {known, !known} : 2'h0);
    @(negedge clk_sys_i);
    if (q[21:19] == 3'h1)
      case (c)
        DIOC_CMD_INV_OFF: exp_f[1] = 1'b0;
        DIOC_CMD_INV_ON: exp_f[1] = 1'b1;
        DIOC_CMD_DISP_OFF: exp_f[0] = 1'b0;
        DIOC_CMD_DISP_ON: exp_f[0] = 1'b1;
        default: ;
      endcase
    chk({inv_on, disp_on}, exp_f);
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (20) @(negedge clk_sys_i);
    srst_i = 1'b0;
    chk({inv_on, disp_on}, 2'h0);
    pixels(3);
    for (int i = 0; i < 60; i++)
    begin
      r = $random(seed);
      cmd(r[2] ? tbl[r[1:0]] : r[10:3], r[5:4] != 2'h0);
      pixels(r[13:12] + 1);
    end
    cmd(DIOC_CMD_DISP_ON, 1'b1);
    cmd(DIOC_CMD_INV_ON, 1'b1);
    cmd(DIOC_CMD_INV_ON, 1'b1);
    sw_reset_i = 1'b1;
    @(negedge clk_sys_i);
    sw_reset_i = 1'b0;
    exp_f = 2'h0;
    chk({inv_on, disp_on}, exp_f);
    cmd(DIOC_CMD_DISP_ON, 1'b1);
    cmd(DIOC_CMD_INV_ON, 1'b1);
    srst_i = 1'b1;
    @(negedge clk_sys_i);
    srst_i = 1'b0;
    exp_f = 2'h0;
    chk({inv_on, disp_on}, exp_f);
    pixels(2);
    give_verdict;
  end
endmodule
`default_nettype wire
